// ---- rtl/cao_core.sv ----
`include "cao_defines.svh"
`default_nettype none
// Notes on behaviour
// - Borrow subtract takes operand and carry from accumulator, updates all five flags.
// - Register borrow subtract takes four states; pointer-addressed form takes seven.
// - Immediate borrow subtract uses byte two, seven states, all five flags.
// - Register plus or minus one: five states, flags except carry updated.
// - Memory plus one rewrites the pointed byte in ten states, carry kept.
// - Memory minus one rewrites the pointed byte in ten states, carry kept.
// - Pair plus one treats the pair as sixteen bits, five states, no flags.
// - Pair minus one treats the pair as sixteen bits, five states, no flags.
// - Pair sum into pointer sets carry from bit fifteen only, ten states.
// - Decimal adjust adds six when low nibble exceeds nine or half carry set.
// - Decimal adjust adds six to high nibble when above nine or carry set.
// - Decimal adjust flags follow the additions made; none made clears them.
// - Logical forms set flags from their result unless told otherwise.
// - AND forms write accumulator and clear carry and half carry.
// - Immediate AND takes seven states, register AND takes four.
// - Exclusive-OR forms write accumulator and clear carry and half carry.
// - Immediate and memory exclusive-OR take seven states, register form four.
// - Inclusive-OR forms write accumulator and clear carry and half carry.
// - Memory OR reads the pointed byte in seven states, register form four.
// - Memory AND and memory borrow subtract read the byte the pointer addresses.
// - Subtraction is two's complement; carry set on borrow, cleared otherwise.
module cao_core (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] imm_i,
  input wire logic load_en_i,
  input wire logic [2:0] load_sel_i,
  input wire logic [7:0] load_data_i,
  input wire logic [7:0] mem_rdata_i,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o,
  output logic [1:0] mcycles_o,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  output logic [7:0] acc_o,
  output logic [15:0] pair_bc_o,
  output logic [15:0] pair_de_o,
  output logic [15:0] pair_hl_o,
  output logic [15:0] sp_o,
  output logic result_null_o,
  output logic negative_o,
  output logic even_ones_o,
  output logic carry_flag_o,
  output logic half_carry_flag_o
);

  function automatic cao_pkg::cao_op_t decode_op(input logic [7:0] opc);
    cao_pkg::cao_op_t op;
    op = cao_pkg::CAO_OP_NONE;
    if ((opc & `CAO_MASK_SRC) == `CAO_PAT_SBB || opc == `CAO_OPC_SBI) begin
      op = cao_pkg::CAO_OP_SBB;
    end else if ((opc & `CAO_MASK_SRC) == `CAO_PAT_AND || opc == `CAO_OPC_ANI) begin
      op = cao_pkg::CAO_OP_AND;
    end else if ((opc & `CAO_MASK_SRC) == `CAO_PAT_XOR || opc == `CAO_OPC_XRI) begin
      op = cao_pkg::CAO_OP_XOR;
    end else if ((opc & `CAO_MASK_SRC) == `CAO_PAT_OR || opc == `CAO_OPC_ORI) begin
      op = cao_pkg::CAO_OP_OR;
    end else if ((opc & `CAO_MASK_DST) == `CAO_PAT_INR) begin
      op = cao_pkg::CAO_OP_INR;
    end else if ((opc & `CAO_MASK_DST) == `CAO_PAT_DCR) begin
      op = cao_pkg::CAO_OP_DCR;
    end else if ((opc & `CAO_MASK_RP) == `CAO_PAT_INX) begin
      op = cao_pkg::CAO_OP_INX;
    end else if ((opc & `CAO_MASK_RP) == `CAO_PAT_DCX) begin
      op = cao_pkg::CAO_OP_DCX;
    end else if ((opc & `CAO_MASK_RP) == `CAO_PAT_DAD) begin
      op = cao_pkg::CAO_OP_DAD;
    end else if (opc == `CAO_OPC_DAA) begin
      op = cao_pkg::CAO_OP_DAA;
    end
    return op;
  endfunction

  function automatic cao_pkg::cao_src_t decode_src(input logic [7:0] opc);
    cao_pkg::cao_op_t op;
    cao_pkg::cao_src_t src;
    op = decode_op(opc);
    src = cao_pkg::CAO_SRC_REG;
    if (opc[7:6] == 2'b11) begin
      src = cao_pkg::CAO_SRC_IMM;
    end else if (opc[7:6] == 2'b10 && opc[2:0] == `CAO_REG_MEM) begin
      src = cao_pkg::CAO_SRC_MEM;
    end else if ((op == cao_pkg::CAO_OP_INR || op == cao_pkg::CAO_OP_DCR)
                 && opc[5:3] == `CAO_REG_MEM) begin
      src = cao_pkg::CAO_SRC_MEM;
    end
    return src;
  endfunction

  function automatic logic [4:0] state_count(input cao_pkg::cao_op_t op,
                                             input cao_pkg::cao_src_t src);
    logic [4:0] n;
    case (op)
      cao_pkg::CAO_OP_INR, cao_pkg::CAO_OP_DCR: begin
        n = (src == cao_pkg::CAO_SRC_MEM) ? `CAO_ST_INR_MEM : `CAO_ST_INR;
      end
      cao_pkg::CAO_OP_INX, cao_pkg::CAO_OP_DCX: n = `CAO_ST_PAIR;
      cao_pkg::CAO_OP_DAD: n = `CAO_ST_DAD;
      cao_pkg::CAO_OP_DAA: n = `CAO_ST_DAA;
      default: begin
        n = (src == cao_pkg::CAO_SRC_REG) ? `CAO_ST_REG : `CAO_ST_MEM;
      end
    endcase
    return n;
  endfunction

  function automatic logic [1:0] cycle_count(input logic [4:0] n);
    logic [1:0] m;
    case (n)
      `CAO_ST_MEM: m = `CAO_MC_TWO;
      `CAO_ST_DAD: m = `CAO_MC_THREE;
      default: m = `CAO_MC_ONE;
    endcase
    return m;
  endfunction

  cao_pkg::cao_state_t state;
  cao_pkg::cao_op_t op;
  cao_pkg::cao_src_t src;
  logic [7:0] opc;
  logic [7:0] operand;
  logic [4:0] count;
  logic [4:0] last;
  logic [7:0] gpr [0:7];
  logic [15:0] sp;
  logic fl_null;
  logic fl_neg;
  logic fl_even;
  logic fl_cy;
  logic fl_ac;
  logic [15:0] hl;
  logic [15:0] sel_pair;
  logic [7:0] sel_src;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic alu_null;
  logic alu_neg;
  logic alu_even;
  logic alu_cy;
  logic alu_ac;
  logic [15:0] pair_res;
  logic pair_cy;
  logic commit;
  logic take;
  cao_pkg::cao_op_t next_op;
  cao_pkg::cao_src_t next_src;

  assign hl = {gpr[`CAO_REG_H], gpr[`CAO_REG_L]};
  assign next_op = decode_op(opcode_i);
  assign next_src = decode_src(opcode_i);
  assign take = (state == cao_pkg::CAO_ST_IDLE) && start_i;
  assign commit = (state == cao_pkg::CAO_ST_RUN) && (count == last);

  always_comb begin
    case (opc[5:4])
      `CAO_RP_BC: sel_pair = {gpr[`CAO_REG_B], gpr[`CAO_REG_C]};
      `CAO_RP_DE: sel_pair = {gpr[`CAO_REG_D], gpr[`CAO_REG_E]};
      `CAO_RP_HL: sel_pair = hl;
      default: sel_pair = sp;
    endcase
    if (src == cao_pkg::CAO_SRC_REG) begin
      sel_src = gpr[opc[2:0]];
    end else begin
      sel_src = operand;
    end
    if (op == cao_pkg::CAO_OP_INR || op == cao_pkg::CAO_OP_DCR) begin
      alu_a = (src == cao_pkg::CAO_SRC_MEM) ? operand : gpr[opc[5:3]];
    end else begin
      alu_a = gpr[`CAO_REG_A];
    end
    alu_b = sel_src;
  end

  cao_alu u_alu (
    .op_i(op),
    .a_i(alu_a),
    .b_i(alu_b),
    .carry_i(fl_cy),
    .half_carry_i(fl_ac),
    .result_o(alu_res),
    .result_null_o(alu_null),
    .negative_o(alu_neg),
    .even_ones_o(alu_even),
    .carry_o(alu_cy),
    .half_carry_o(alu_ac)
  );

  cao_pair u_pair (
    .op_i(op),
    .x_i((op == cao_pkg::CAO_OP_DAD) ? hl : sel_pair),
    .y_i(sel_pair),
    .result_o(pair_res),
    .carry_o(pair_cy)
  );

  // Sequencer: one state per clock, commit on the last state of the form.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= cao_pkg::CAO_ST_IDLE;
      count <= 5'h00;
    end else begin
      case (state)
        cao_pkg::CAO_ST_IDLE: begin
          count <= 5'h00;
          if (take && next_op != cao_pkg::CAO_OP_NONE) begin
            state <= cao_pkg::CAO_ST_RUN;
          end
        end
        cao_pkg::CAO_ST_RUN: begin
          count <= count + 5'h01;
          if (commit) begin
            state <= cao_pkg::CAO_ST_END;
          end
        end
        cao_pkg::CAO_ST_END: state <= cao_pkg::CAO_ST_IDLE;
        default: state <= cao_pkg::CAO_ST_IDLE;
      endcase
    end
  end

  // Instruction capture.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opc <= `CAO_RST_BYTE;
      op <= cao_pkg::CAO_OP_NONE;
      src <= cao_pkg::CAO_SRC_REG;
      last <= 5'h00;
      mcycles_o <= 2'h0;
    end else if (take) begin
      opc <= opcode_i;
      op <= next_op;
      src <= next_src;
      last <= state_count(next_op, next_src) - 5'h01;
      mcycles_o <= cycle_count(state_count(next_op, next_src));
    end
  end

  // Operand latch: immediate byte at start, memory byte two states after the read.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      operand <= `CAO_RST_BYTE;
    end else if (take) begin
      operand <= imm_i;
    end else if (state == cao_pkg::CAO_ST_RUN && src == cao_pkg::CAO_SRC_MEM
                 && count == `CAO_RD_TAKE) begin
      operand <= mem_rdata_i;
    end
  end

  // Memory port, always addressed by the pointer pair.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_addr_o <= `CAO_RST_WORD;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= `CAO_RST_BYTE;
    end else begin
      mem_addr_o <= hl;
      mem_rd_o <= (state == cao_pkg::CAO_ST_RUN) && (src == cao_pkg::CAO_SRC_MEM)
                  && (count == `CAO_RD_ISSUE);
      mem_wr_o <= commit && (src == cao_pkg::CAO_SRC_MEM)
                  && (op == cao_pkg::CAO_OP_INR || op == cao_pkg::CAO_OP_DCR);
      if (commit) begin
        mem_wdata_o <= alu_res;
      end
    end
  end

  // Register file and stack pointer.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 8; i++) begin
        gpr[i] <= `CAO_RST_BYTE;
      end
      sp <= `CAO_RST_WORD;
    end else if (commit) begin
      case (op)
        cao_pkg::CAO_OP_SBB, cao_pkg::CAO_OP_AND, cao_pkg::CAO_OP_XOR, cao_pkg::CAO_OP_OR,
        cao_pkg::CAO_OP_DAA: begin
          gpr[`CAO_REG_A] <= alu_res;
        end
        cao_pkg::CAO_OP_INR, cao_pkg::CAO_OP_DCR: begin
          if (src == cao_pkg::CAO_SRC_REG) begin
            gpr[opc[5:3]] <= alu_res;
          end
        end
        cao_pkg::CAO_OP_DAD: begin
          gpr[`CAO_REG_H] <= pair_res[15:8];
          gpr[`CAO_REG_L] <= pair_res[7:0];
        end
        cao_pkg::CAO_OP_INX, cao_pkg::CAO_OP_DCX: begin
          case (opc[5:4])
            `CAO_RP_BC: {gpr[`CAO_REG_B], gpr[`CAO_REG_C]} <= pair_res;
            `CAO_RP_DE: {gpr[`CAO_REG_D], gpr[`CAO_REG_E]} <= pair_res;
            `CAO_RP_HL: {gpr[`CAO_REG_H], gpr[`CAO_REG_L]} <= pair_res;
            default: sp <= pair_res;
          endcase
        end
        default: sp <= sp;
      endcase
    end else if (load_en_i && state == cao_pkg::CAO_ST_IDLE
                 && load_sel_i != `CAO_LOAD_FLAGS) begin
      gpr[load_sel_i] <= load_data_i;
    end
  end

  // Condition flags.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {fl_null, fl_neg, fl_even, fl_cy, fl_ac} <= 5'h00;
    end else if (commit) begin
      case (op)
        cao_pkg::CAO_OP_INX, cao_pkg::CAO_OP_DCX: fl_cy <= fl_cy;
        cao_pkg::CAO_OP_DAD: fl_cy <= pair_cy;
        default: begin
          fl_null <= alu_null;
          fl_neg <= alu_neg;
          fl_even <= alu_even;
          fl_cy <= alu_cy;
          fl_ac <= alu_ac;
        end
      endcase
    end else if (load_en_i && state == cao_pkg::CAO_ST_IDLE
                 && load_sel_i == `CAO_LOAD_FLAGS) begin
      {fl_null, fl_neg, fl_even, fl_cy, fl_ac} <= load_data_i[4:0];
    end
  end

  // Status pulses.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_o <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      done_o <= commit;
      illegal_o <= take && (next_op == cao_pkg::CAO_OP_NONE);
    end
  end

  assign busy_o = (state != cao_pkg::CAO_ST_IDLE);
  assign acc_o = gpr[`CAO_REG_A];
  assign pair_bc_o = {gpr[`CAO_REG_B], gpr[`CAO_REG_C]};
  assign pair_de_o = {gpr[`CAO_REG_D], gpr[`CAO_REG_E]};
  assign pair_hl_o = hl;
  assign sp_o = sp;
  assign result_null_o = fl_null;
  assign negative_o = fl_neg;
  assign even_ones_o = fl_even;
  assign carry_flag_o = fl_cy;
  assign half_carry_flag_o = fl_ac;

endmodule
`default_nettype wire

// ---- rtl/cao_defines.svh ----
`ifndef CAO_DEFINES_SVH
`define CAO_DEFINES_SVH

// Opcode patterns and the masks that select the fixed bits of each family.
`define CAO_MASK_SRC 8'hF8
`define CAO_MASK_DST 8'hC7
`define CAO_MASK_RP 8'hCF
`define CAO_PAT_SBB 8'h98
`define CAO_PAT_AND 8'hA0
`define CAO_PAT_XOR 8'hA8
`define CAO_PAT_OR 8'hB0
`define CAO_PAT_INR 8'h04
`define CAO_PAT_DCR 8'h05
`define CAO_PAT_INX 8'h03
`define CAO_PAT_DCX 8'h0B
`define CAO_PAT_DAD 8'h09
`define CAO_OPC_SBI 8'hDE
`define CAO_OPC_ANI 8'hE6
`define CAO_OPC_XRI 8'hEE
`define CAO_OPC_ORI 8'hF6
`define CAO_OPC_DAA 8'h27

// Register field codes; code 6 names the byte addressed by the pointer pair.
`define CAO_REG_B 3'h0
`define CAO_REG_C 3'h1
`define CAO_REG_D 3'h2
`define CAO_REG_E 3'h3
`define CAO_REG_H 3'h4
`define CAO_REG_L 3'h5
`define CAO_REG_MEM 3'h6
`define CAO_REG_A 3'h7

// Pair field codes.
`define CAO_RP_BC 2'h0
`define CAO_RP_DE 2'h1
`define CAO_RP_HL 2'h2
`define CAO_RP_SP 2'h3

// Machine cycles and states of each form; one state is one clock.
`define CAO_ST_REG 5'h04
`define CAO_ST_MEM 5'h07
`define CAO_ST_IMM 5'h07
`define CAO_ST_INR 5'h05
`define CAO_ST_INR_MEM 5'h0A
`define CAO_ST_PAIR 5'h05
`define CAO_ST_DAD 5'h0A
`define CAO_ST_DAA 5'h04
`define CAO_MC_ONE 2'h1
`define CAO_MC_TWO 2'h2
`define CAO_MC_THREE 2'h3

// State at which a memory read is issued and the state its data is taken.
`define CAO_RD_ISSUE 5'h00
`define CAO_RD_TAKE 5'h02

// Decimal adjust constants.
`define CAO_BCD_LIMIT 4'h9
`define CAO_BCD_LO_STEP 8'h06
`define CAO_BCD_HI_STEP 8'h60

// Reset values and the load select code that writes the flags.
`define CAO_RST_BYTE 8'h00
`define CAO_RST_WORD 16'h0000
`define CAO_LOAD_FLAGS 3'h6

`endif

// ---- rtl/cao_pkg.sv ----
`default_nettype none
package cao_pkg;

  typedef enum logic [3:0] {
    CAO_OP_NONE = 4'h0,
    CAO_OP_SBB = 4'h1,
    CAO_OP_INR = 4'h2,
    CAO_OP_DCR = 4'h3,
    CAO_OP_INX = 4'h4,
    CAO_OP_DCX = 4'h5,
    CAO_OP_DAD = 4'h6,
    CAO_OP_DAA = 4'h7,
    CAO_OP_AND = 4'h8,
    CAO_OP_XOR = 4'h9,
    CAO_OP_OR = 4'hA
  } cao_op_t;

  typedef enum logic [1:0] {
    CAO_SRC_REG = 2'h0,
    CAO_SRC_MEM = 2'h1,
    CAO_SRC_IMM = 2'h2
  } cao_src_t;

  typedef enum logic [2:0] {
    CAO_ST_IDLE = 3'b001,
    CAO_ST_RUN = 3'b010,
    CAO_ST_END = 3'b100
  } cao_state_t;

endpackage
`default_nettype wire

// ---- rtl/cao_alu.sv ----
`include "cao_defines.svh"
`default_nettype none
module cao_alu (
  input wire cao_pkg::cao_op_t op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic carry_i,
  input wire logic half_carry_i,
  output logic [7:0] result_o,
  output logic result_null_o,
  output logic negative_o,
  output logic even_ones_o,
  output logic carry_o,
  output logic half_carry_o
);

  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] step1;
  logic fix_lo;
  logic fix_hi;
  logic kill_flags;

  always_comb begin
    sum = 9'h000;
    low = 5'h00;
    step1 = a_i;
    fix_lo = 1'b0;
    fix_hi = 1'b0;
    kill_flags = 1'b0;
    result_o = a_i;
    carry_o = carry_i;
    half_carry_o = half_carry_i;
    case (op_i)
      cao_pkg::CAO_OP_SBB: begin
        sum = {1'b0, a_i} + {1'b0, ~b_i} + {8'h00, ~carry_i};
        low = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + {4'h0, ~carry_i};
        result_o = sum[7:0];
        carry_o = ~sum[8];
        half_carry_o = low[4];
      end
      cao_pkg::CAO_OP_INR: begin
        result_o = a_i + 8'h01;
        half_carry_o = (a_i[3:0] == 4'hF);
      end
      cao_pkg::CAO_OP_DCR: begin
        result_o = a_i - 8'h01;
        half_carry_o = (a_i[3:0] != 4'h0);
      end
      cao_pkg::CAO_OP_AND: begin
        result_o = a_i & b_i;
        carry_o = 1'b0;
        half_carry_o = 1'b0;
      end
      cao_pkg::CAO_OP_XOR: begin
        result_o = a_i ^ b_i;
        carry_o = 1'b0;
        half_carry_o = 1'b0;
      end
      cao_pkg::CAO_OP_OR: begin
        result_o = a_i | b_i;
        carry_o = 1'b0;
        half_carry_o = 1'b0;
      end
      cao_pkg::CAO_OP_DAA: begin
        fix_lo = (a_i[3:0] > `CAO_BCD_LIMIT) || half_carry_i;
        sum = fix_lo ? {1'b0, a_i} + {1'b0, `CAO_BCD_LO_STEP} : {1'b0, a_i};
        low = {1'b0, a_i[3:0]} + {1'b0, 4'(`CAO_BCD_LO_STEP)};
        step1 = sum[7:0];
        fix_hi = (step1[7:4] > `CAO_BCD_LIMIT) || carry_i;
        half_carry_o = fix_lo & low[4];
        carry_o = sum[8];
        sum = fix_hi ? {1'b0, step1} + {1'b0, `CAO_BCD_HI_STEP} : {1'b0, step1};
        result_o = sum[7:0];
        carry_o = carry_o | (fix_hi & sum[8]);
        kill_flags = ~fix_lo & ~fix_hi;
        if (kill_flags) begin
          carry_o = 1'b0;
          half_carry_o = 1'b0;
        end
      end
      default: begin
        result_o = a_i;
      end
    endcase
    result_null_o = ~kill_flags & (result_o == 8'h00);
    negative_o = ~kill_flags & result_o[7];
    even_ones_o = ~kill_flags & ~(^result_o);
  end

endmodule
`default_nettype wire

// ---- rtl/cao_pair.sv ----
`include "cao_defines.svh"
`default_nettype none
module cao_pair (
  input wire cao_pkg::cao_op_t op_i,
  input wire logic [15:0] x_i,
  input wire logic [15:0] y_i,
  output logic [15:0] result_o,
  output logic carry_o
);

  logic [16:0] sum;

  always_comb begin
    sum = {1'b0, x_i};
    case (op_i)
      cao_pkg::CAO_OP_INX: sum = {1'b0, x_i} + 17'h00001;
      cao_pkg::CAO_OP_DCX: sum = {1'b0, x_i} - 17'h00001;
      cao_pkg::CAO_OP_DAD: sum = {1'b0, x_i} + {1'b0, y_i};
      default: sum = {1'b0, x_i};
    endcase
    result_o = sum[15:0];
    carry_o = sum[16];
  end

endmodule
`default_nettype wire

// ---- tb/cao_core_asserts.sv ----
`default_nettype none
module cao_core_asserts (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [15:0] pair_hl_o,
  input wire logic result_null_o,
  input wire logic negative_o,
  input wire logic even_ones_o,
  input wire logic carry_flag_o,
  input wire logic half_carry_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  wire logic take = start_i && !busy_o;
  wire logic reg4 = opcode_i[7:3] inside {5'h13, 5'h14, 5'h15, 5'h16} && opcode_i[2:0] != 3'h6;
  wire logic mem7 = opcode_i inside {8'h9E, 8'hA6, 8'hAE, 8'hB6, 8'hDE, 8'hE6, 8'hEE, 8'hF6};
  wire logic step1 = (opcode_i & 8'hC6) == 8'h04;
  wire logic pair1 = (opcode_i & 8'hC7) == 8'h03;
  logic [7:0] last_op;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_op <= 8'h00;
    end else if (take) begin
      last_op <= opcode_i;
    end
  end
  wire logic logic_op = (last_op[7:5] == 3'h5 && last_op[4:3] != 2'h3) ||
                        last_op inside {8'hE6, 8'hEE, 8'hF6};
  AST_DONE_ONE: assert property (done_o |=> !done_o)
    else $error("done pulse longer than one cycle");
  AST_FOUR_STATES: assert property (take && reg4 |=> !done_o[*4] ##1 done_o)
    else $error("register form did not take four states");
  AST_SEVEN_STATES: assert property (take && mem7 |=> !done_o[*7] ##1 done_o)
    else $error("memory or immediate form did not take seven states");
  AST_FIVE_STATES: assert property (
    (take && opcode_i[5:3] != 3'h6 && step1) || (take && pair1) |=> !done_o[*5] ##1 done_o)
    else $error("single step form did not take five states");
  AST_TEN_STATES: assert property (
    take && (opcode_i inside {8'h34, 8'h35} || (opcode_i & 8'hCF) == 8'h09)
    |=> !done_o[*8] ##1 !done_o[*2] ##1 done_o)
    else $error("ten state form did not take ten states");
  AST_CARRY_KEPT: assert property (
    take && step1 |=> $stable(carry_flag_o)[*6])
    else $error("plus or minus one changed carry");
  AST_PAIR_NO_FLAGS: assert property (
    take && pair1 |=> $stable({result_null_o, negative_o, even_ones_o, carry_flag_o,
    half_carry_flag_o})[*6])
    else $error("pair step changed a flag");
  AST_LOGIC_CLEAR: assert property (
    done_o && logic_op |-> !carry_flag_o && !half_carry_flag_o)
    else $error("logical form left carry or half carry set");
  AST_READ_POINTER: assert property (
    mem_rd_o |-> mem_addr_o == pair_hl_o ##1 !mem_rd_o)
    else $error("memory read not at pointer pair");
  AST_WRITE_AT_END: assert property (mem_wr_o |-> done_o)
    else $error("memory write outside the final state");
  cover property (take && opcode_i == 8'h9E);
  cover property (mem_wr_o && done_o);
  cover property (done_o && logic_op);
endmodule

bind cao_core cao_core_asserts u_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .start_i(start_i), .opcode_i(opcode_i),
  .busy_o(busy_o), .done_o(done_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
  .mem_addr_o(mem_addr_o), .pair_hl_o(pair_hl_o), .result_null_o(result_null_o),
  .negative_o(negative_o), .even_ones_o(even_ones_o), .carry_flag_o(carry_flag_o),
  .half_carry_flag_o(half_carry_flag_o)
);
`default_nettype wire

// ---- tb/cao_core_test.sv ----
`default_nettype none
module cao_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic start_i = 1'b0;
  logic load_en_i = 1'b0;
  logic [2:0] load_sel_i = 3'h0;
  logic [7:0] opcode_i = 8'h00;
  logic [7:0] imm_i = 8'h00;
  logic [7:0] load_data_i = 8'h00;
  logic [7:0] mem_rdata_i = 8'h00;
  logic busy_o, done_o, illegal_o, mem_rd_o, mem_wr_o;
  logic [1:0] mcycles_o;
  logic [7:0] mem_wdata_o, acc_o;
  logic [15:0] mem_addr_o, pair_bc_o, pair_de_o, pair_hl_o, sp_o;
  logic result_null_o, negative_o, even_ones_o, carry_flag_o, half_carry_flag_o;
  int n_fail = 0;
  int comparisons = 0;

  cao_core dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .start_i(start_i), .opcode_i(opcode_i),
    .imm_i(imm_i), .load_en_i(load_en_i), .load_sel_i(load_sel_i), .load_data_i(load_data_i),
    .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o),
    .mcycles_o(mcycles_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_wdata_o(mem_wdata_o), .acc_o(acc_o), .pair_bc_o(pair_bc_o), .pair_de_o(pair_de_o),
    .pair_hl_o(pair_hl_o), .sp_o(sp_o), .result_null_o(result_null_o), .negative_o(negative_o),
    .even_ones_o(even_ones_o), .carry_flag_o(carry_flag_o),
    .half_carry_flag_o(half_carry_flag_o)
  );

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkf(input logic [4:0] exp);
    chk8("flags", {3'h0, exp}, {3'h0, result_null_o, negative_o, even_ones_o, carry_flag_o,
         half_carry_flag_o});
  endtask

  function automatic logic [2:0] zsp(input logic [7:0] r);
    return {r == 8'h00, r[7], ~^r};
  endfunction

  task automatic report_and_stop;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic load(input logic [2:0] sel, input logic [7:0] d);
    @(negedge clk_sys_i);
    load_en_i = 1'b1;
    load_sel_i = sel;
    load_data_i = d;
    @(negedge clk_sys_i);
    load_en_i = 1'b0;
  endtask

  // Runs one instruction and stops in the cycle where done is visible.
  task automatic exec(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] mem,
                      input int n, input logic [1:0] mc, input logic m);
    int k;
    logic rd;
    @(negedge clk_sys_i);
    start_i = 1'b1;
    opcode_i = op;
    imm_i = b2;
    mem_rdata_i = mem;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    k = 0;
    rd = 1'b0;
    while (done_o !== 1'b1 && k < 40) begin
      if (mem_rd_o === 1'b1) begin
        rd = 1'b1;
        chk16("read address", 16'h1234, mem_addr_o);
      end
      @(negedge clk_sys_i);
      k++;
    end
    mem_rdata_i = ~mem;
    if (k == 40) begin
      n_fail++;
      report_and_stop();
    end
    chk16("states", 16'(n), 16'(k));
    chk8("machine cycles", {6'h00, mc}, {6'h00, mcycles_o});
    chk8("memory read", {7'h00, m}, {7'h00, rd});
  endtask

  task automatic t_sbb;
    load(3'h4, 8'h12);
    load(3'h5, 8'h34);
    load(3'h7, 8'h10);
    load(3'h0, 8'h20);
    load(3'h6, 8'h02);
    exec(8'h98, 8'hC3, 8'hC3, 4, 2'h1, 1'b0);
    chk8("acc", 8'hEF, acc_o);
    chkf(5'b01010);
    exec(8'h9E, 8'hC3, 8'h0E, 7, 2'h2, 1'b1);
    chk8("acc", 8'hE0, acc_o);
    chkf(5'b01001);
    exec(8'hDE, 8'hE0, 8'h55, 7, 2'h2, 1'b0);
    chk8("acc", 8'h00, acc_o);
    chkf(5'b10101);
  endtask

  task automatic t_incdec;
    load(3'h0, 8'h0F);
    load(3'h1, 8'h00);
    load(3'h6, 8'h02);
    exec(8'h04, 8'h00, 8'h00, 5, 2'h1, 1'b0);
    chkf(5'b00011);
    exec(8'h0D, 8'h00, 8'h00, 5, 2'h1, 1'b0);
    chk16("pair bc", 16'h10FF, pair_bc_o);
    chkf(5'b01110);
    exec(8'h34, 8'h00, 8'h7F, 10, 2'h3, 1'b1);
    chk8("write strobe", 8'h01, {7'h00, mem_wr_o});
    chk8("write data", 8'h80, mem_wdata_o);
    chkf(5'b01011);
    exec(8'h35, 8'h00, 8'h01, 10, 2'h3, 1'b1);
    chk8("write data", 8'h00, mem_wdata_o);
    chkf(5'b10111);
  endtask

  task automatic t_logic;
    logic [7:0] ops [9] = '{8'hA0, 8'hA8, 8'hB0, 8'hE6, 8'hEE, 8'hF6, 8'hA6, 8'hAE, 8'hB6};
    logic [7:0] e;
    logic [7:0] b2;
    logic [7:0] mb;
    load(3'h0, 8'h3D);
    for (int i = 0; i < 9; i++) begin
      load(3'h7, 8'hF0);
      load(3'h6, 8'h03);
      b2 = (i >= 3 && i < 6) ? 8'h3D : 8'hC3;
      mb = (i >= 6) ? 8'h3D : 8'hC3;
      e = (i % 3 == 0) ? (8'hF0 & 8'h3D) : (i % 3 == 1) ? (8'hF0 ^ 8'h3D) : (8'hF0 | 8'h3D);
      exec(ops[i], b2, mb, (i < 3) ? 4 : 7, (i < 3) ? 2'h1 : 2'h2, i >= 6);
      chk8("acc", e, acc_o);
      chkf({zsp(e), 2'b00});
    end
  endtask

  task automatic t_daa;
    logic [7:0] ain [3] = '{8'h9B, 8'h12, 8'h12};
    logic [7:0] fin [3] = '{8'h00, 8'h01, 8'h0C};
    logic [7:0] aout [3] = '{8'h01, 8'h18, 8'h12};
    logic [4:0] fout [3] = '{5'b00011, 5'b00100, 5'b00000};
    for (int i = 0; i < 3; i++) begin
      load(3'h7, ain[i]);
      load(3'h6, fin[i]);
      exec(8'h27, 8'h00, 8'h00, 4, 2'h1, 1'b0);
      chk8("acc", aout[i], acc_o);
      chkf(fout[i]);
    end
  endtask

  task automatic t_pair;
    load(3'h6, 8'h15);
    load(3'h1, 8'hFF);
    load(3'h0, 8'h00);
    load(3'h2, 8'h00);
    load(3'h3, 8'h00);
    exec(8'h03, 8'h00, 8'h00, 5, 2'h1, 1'b0);
    chk16("pair bc", 16'h0100, pair_bc_o);
    exec(8'h1B, 8'h00, 8'h00, 5, 2'h1, 1'b0);
    chk16("pair de", 16'hFFFF, pair_de_o);
    exec(8'h33, 8'h00, 8'h00, 5, 2'h1, 1'b0);
    chk16("stack pointer", 16'h0001, sp_o);
    chkf(5'b10101);
    exec(8'h19, 8'h00, 8'h00, 10, 2'h3, 1'b0);
    chk16("pair hl", 16'h1233, pair_hl_o);
    chkf(5'b10111);
    exec(8'h09, 8'h00, 8'h00, 10, 2'h3, 1'b0);
    chk16("pair hl", 16'h1333, pair_hl_o);
    chkf(5'b10101);
  endtask

  task automatic t_illegal;
    @(negedge clk_sys_i);
    start_i = 1'b1;
    opcode_i = 8'h76;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    chk8("illegal pulse", 8'h01, {7'h00, illegal_o});
    chk8("busy", 8'h00, {7'h00, busy_o});
    @(negedge clk_sys_i);
    chk8("illegal pulse", 8'h00, {7'h00, illegal_o});
    chk8("acc", 8'h12, acc_o);
  endtask

  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    repeat (16) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    chk8("acc after reset", 8'h00, acc_o);
    t_sbb();
    t_incdec();
    t_logic();
    t_daa();
    t_pair();
    t_illegal();
    report_and_stop();
  end
endmodule
`default_nettype wire
